// file: hdl/scdiv_pkg.sv
/*
  Package for the system clock divider block: register offsets, field
  positions, reset codes, boot decode table, state codes and carriers.
  Assumes it is compiled before every other file of the block.
*/
package scdiv_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [15:0] CTRL_OFFSET = 16'h1044;
  localparam logic [15:0] STAT_OFFSET = 16'h1100;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int CORE_MSB = 31;
  localparam int CORE_LSB = 28;
  localparam int BUS_MSB = 18;
  localparam int BUS_LSB = 16;
  localparam int CORE_W = 4;
  localparam int BUS_W = 3;
  localparam int CORE_LANE = 3;
  localparam int BUS_LANE = 2;

  // reset codes: core divide-by-1 until the boot load, bus divide-by-2
  localparam logic [3:0] CORE_RESET = 4'h0;
  localparam logic [2:0] BUS_RESET = 3'h1;

  // boot option bits -> core divide code (index is the two-bit option)
  localparam logic [3:0] BOOT_CODE_0 = 4'h7;
  localparam logic [3:0] BOOT_CODE_1 = 4'h3;
  localparam logic [3:0] BOOT_CODE_2 = 4'h1;
  localparam logic [3:0] BOOT_CODE_3 = 4'h0;

  // ----------------------------------------------------------------
  // status register fields
  // ----------------------------------------------------------------
  localparam int STAT_LOW_RUN_BIT = 0;
  localparam int STAT_READY_BIT = 1;
  localparam int STAT_CORE_LSB = 4;
  localparam int STAT_BUS_LSB = 8;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [3:0] core;
    logic [2:0] bus;
  } scdiv_ratio_s;

  typedef enum logic [4:0] {
    BOOT_WAIT0  = 5'b0_0001,
    BOOT_WAIT1  = 5'b0_0010,
    BOOT_LOAD   = 5'b0_0100,
    BOOT_SETTLE = 5'b0_1000,
    BOOT_RUN    = 5'b1_0000
  } scdiv_boot_e;

endpackage

// file: hdl/scdiv_ratio_div.sv
/*
  Ratio divider producing a one-cycle enable pulse every (code+1)
  input ticks. Assumes tick_in is a one-cycle enable on clk.
*/
`timescale 1ns/1ps
`default_nettype none
module scdiv_ratio_div #(
  parameter int W = 4,
  parameter logic [W-1:0] RESET_CODE = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick_in,
  input wire logic [W-1:0] ratio_code,
  output logic tick_out,
  output logic [W-1:0] active_code
);

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic [W-1:0] act_reg;
  logic [W-1:0] act_next;
  logic wrap;

  assign wrap = tick_in && (cnt_reg == act_reg);

  // new code taken only at a period end, so no period is ever cut short
  always_comb begin
    cnt_next = cnt_reg;
    act_next = act_reg;
    if (wrap) begin
      cnt_next = '0;
      act_next = ratio_code;
    end else if (tick_in) begin
      cnt_next = cnt_reg + W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
      act_reg <= RESET_CODE;
    end else begin
      cnt_reg <= cnt_next;
      act_reg <= act_next;
    end
  end

  assign tick_out = wrap;
  assign active_code = act_reg;

endmodule
`default_nettype wire

// file: hdl/scdiv_sync2.sv
/*
  Two-flop synchroniser for level inputs arriving from outside pclk.
  Assumes the inputs are quasi-static levels; multi-bit values must be
  stable for several cycles around the point at which they are used.
*/
`timescale 1ns/1ps
`default_nettype none
module scdiv_sync2 #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q_reg <= '0;
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;

endmodule
`default_nettype wire

// file: hdl/scdiv_top.sv
/*
  System clock divider control: APB slave holding the divider control
  register and a status register, boot-option load after reset, the
  very low power run write lock, and two chained ratio dividers that
  give core and bus/flash clock enables.
  Assumes an APB master on pclk, and that the mode pin and boot option
  bits are levels from outside pclk, held steady around reset release.
*/
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - writes to the divider register are dropped in very low power run mode.
// - bits 31:28 set the core clock ratio; bus clock derives from it.
// - core ratio equals field value plus one, range one to sixteen.
// - after reset the core field loads from the two boot option bits.
// - bits 18:16 further divide the bus and flash clock.
// - bus ratio equals field value plus one, range one to eight.
// - after reset the bus field holds the divide-by-two code.
module scdiv_top #(
  parameter int ADDR_W = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic very_low_power_run_mode,
  input wire logic [1:0] boot_divide_option_bits,
  output logic core_clk_en,
  output logic bus_flash_clk_en
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic low_run_s;
  logic [1:0] boot_s;

  scdiv_sync2 #(.W(3)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .d({very_low_power_run_mode, boot_divide_option_bits}),
    .q({low_run_s, boot_s})
  );

  // ----------------------------------------------------------------
  // boot sequencer
  // ----------------------------------------------------------------
  scdiv_pkg::scdiv_boot_e boot_reg;
  scdiv_pkg::scdiv_boot_e boot_next;
  logic [3:0] boot_code;

  // decode of the synchronised option bits
  always_comb begin
    unique case (boot_s)
      2'b00: boot_code = scdiv_pkg::BOOT_CODE_0;
      2'b01: boot_code = scdiv_pkg::BOOT_CODE_1;
      2'b10: boot_code = scdiv_pkg::BOOT_CODE_2;
      2'b11: boot_code = scdiv_pkg::BOOT_CODE_3;
    endcase
  end

  // two waits let the synchroniser fill before the option is caught
  always_comb begin
    boot_next = boot_reg;
    unique case (boot_reg)
      scdiv_pkg::BOOT_WAIT0: boot_next = scdiv_pkg::BOOT_WAIT1;
      scdiv_pkg::BOOT_WAIT1: boot_next = scdiv_pkg::BOOT_LOAD;
      scdiv_pkg::BOOT_LOAD: boot_next = scdiv_pkg::BOOT_SETTLE;
      scdiv_pkg::BOOT_SETTLE: boot_next = scdiv_pkg::BOOT_RUN;
      scdiv_pkg::BOOT_RUN: boot_next = scdiv_pkg::BOOT_RUN;
      default: boot_next = scdiv_pkg::BOOT_WAIT0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_reg <= scdiv_pkg::BOOT_WAIT0;
    end else begin
      boot_reg <= boot_next;
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic ctrl_hit;
  logic stat_hit;
  logic run;
  logic access;
  logic wr_ctrl;

  assign ctrl_hit = (paddr == ADDR_W'(scdiv_pkg::CTRL_OFFSET));
  assign stat_hit = (paddr == ADDR_W'(scdiv_pkg::STAT_OFFSET));
  assign run = (boot_reg == scdiv_pkg::BOOT_RUN);
  // bus is held off until the boot load has settled
  assign pready = run;
  assign access = psel && penable && run;
  assign pslverr = access && (!(ctrl_hit || stat_hit) || (pwrite && stat_hit));
  assign wr_ctrl = access && pwrite && ctrl_hit && !low_run_s;

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  scdiv_pkg::scdiv_ratio_s ctrl_reg;
  scdiv_pkg::scdiv_ratio_s ctrl_next;

  // only the two ratio fields are stored; other bits are not kept
  always_comb begin
    ctrl_next = ctrl_reg;
    if (boot_reg == scdiv_pkg::BOOT_LOAD) begin
      ctrl_next.core = boot_code;
      ctrl_next.bus = scdiv_pkg::BUS_RESET;
    end else if (wr_ctrl) begin
      if (pstrb[scdiv_pkg::CORE_LANE]) begin
        ctrl_next.core = pwdata[scdiv_pkg::CORE_MSB:scdiv_pkg::CORE_LSB];
      end
      if (pstrb[scdiv_pkg::BUS_LANE]) begin
        ctrl_next.bus = pwdata[scdiv_pkg::BUS_MSB:scdiv_pkg::BUS_LSB];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg.core <= scdiv_pkg::CORE_RESET;
      ctrl_reg.bus <= scdiv_pkg::BUS_RESET;
    end else begin
      ctrl_reg <= ctrl_next;
    end
  end

  // ----------------------------------------------------------------
  // dividers
  // ----------------------------------------------------------------
  logic [3:0] core_active;
  logic [2:0] bus_active;

  // core divider runs on every pclk edge
  scdiv_ratio_div #(.W(scdiv_pkg::CORE_W), .RESET_CODE(scdiv_pkg::CORE_RESET)) u_core (
    .clk(pclk),
    .rst_n(presetn),
    .tick_in(1'b1),
    .ratio_code(ctrl_reg.core),
    .tick_out(core_clk_en),
    .active_code(core_active)
  );

  // bus divider counts core enables, so its ratio stacks on the core one
  scdiv_ratio_div #(.W(scdiv_pkg::BUS_W), .RESET_CODE(scdiv_pkg::BUS_RESET)) u_bus (
    .clk(pclk),
    .rst_n(presetn),
    .tick_in(core_clk_en),
    .ratio_code(ctrl_reg.bus),
    .tick_out(bus_flash_clk_en),
    .active_code(bus_active)
  );

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;

  // reserved bits fall out as zero from the zero-filled word
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (ctrl_hit) begin
      rd_mux[scdiv_pkg::CORE_MSB:scdiv_pkg::CORE_LSB] = ctrl_reg.core;
      rd_mux[scdiv_pkg::BUS_MSB:scdiv_pkg::BUS_LSB] = ctrl_reg.bus;
    end else if (stat_hit) begin
      rd_mux[scdiv_pkg::STAT_LOW_RUN_BIT] = low_run_s;
      rd_mux[scdiv_pkg::STAT_READY_BIT] = run;
      rd_mux[scdiv_pkg::STAT_CORE_LSB +: scdiv_pkg::CORE_W] = core_active;
      rd_mux[scdiv_pkg::STAT_BUS_LSB +: scdiv_pkg::BUS_W] = bus_active;
    end
  end

  // refreshed every selected read cycle, so the access phase sees it
  always_comb begin
    prdata_next = prdata_reg;
    if (psel && !pwrite) begin
      prdata_next = rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign prdata = prdata_reg;

  // ----------------------------------------------------------------
  // assertion helpers
  // ----------------------------------------------------------------
  logic [3:0] core_gap_reg;
  logic [2:0] bus_gap_reg;
  logic core_seen_reg;
  logic bus_seen_reg;
  logic [3:0] core_gap_next;
  logic [2:0] bus_gap_next;
  logic core_seen_next;
  logic bus_seen_next;

  // distance since the previous enable, in pclk or core enables
  always_comb begin
    core_gap_next = core_clk_en ? 4'h0 : core_gap_reg + 4'h1;
    bus_gap_next = bus_gap_reg;
    core_seen_next = core_seen_reg | core_clk_en;
    bus_seen_next = bus_seen_reg | bus_flash_clk_en;
    if (bus_flash_clk_en) begin
      bus_gap_next = 3'h0;
    end else if (core_clk_en) begin
      bus_gap_next = bus_gap_reg + 3'h1;
    end
  end

  // seen flags keep the first, partial period out of the checks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_gap_reg <= 4'h0;
      bus_gap_reg <= 3'h0;
      core_seen_reg <= 1'b0;
      bus_seen_reg <= 1'b0;
    end else begin
      core_gap_reg <= core_gap_next;
      bus_gap_reg <= bus_gap_next;
      core_seen_reg <= core_seen_next;
      bus_seen_reg <= bus_seen_next;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_LOW_RUN_LOCK: assert property (
    (access && pwrite && ctrl_hit && low_run_s) |=> $stable(ctrl_reg))
    else $error("divider register changed during low power run");

  AST_CORE_WRITE: assert property (
    (wr_ctrl && pstrb[3] && boot_reg == scdiv_pkg::BOOT_RUN)
      |=> ctrl_reg.core == $past(pwdata[31:28]))
    else $error("core field did not take written value");

  AST_CORE_PERIOD: assert property (
    (core_clk_en && core_seen_reg) |-> core_gap_reg == core_active)
    else $error("core enable spacing does not match ratio");

  AST_BOOT_LOAD: assert property (
    (boot_reg == scdiv_pkg::BOOT_LOAD) |=> ##1 (ctrl_reg.core == $past(boot_code, 2)))
    else $error("core field not loaded from boot option");

  AST_RSVD_ZERO: assert property (
    (access && !pwrite && ctrl_hit) |-> (prdata[27:19] == 9'h000 && prdata[15:0] == 16'h0000))
    else $error("reserved bits read nonzero");

  AST_BUS_WRITE: assert property (
    (wr_ctrl && pstrb[2]) |=> ctrl_reg.bus == $past(pwdata[18:16]))
    else $error("bus field did not take written value");

  AST_BUS_PERIOD: assert property (
    (bus_flash_clk_en && bus_seen_reg) |-> bus_gap_reg == bus_active)
    else $error("bus enable spacing does not match ratio");

  AST_BUS_RESET: assert property (
    $rose(run) |-> ctrl_reg.bus == scdiv_pkg::BUS_RESET)
    else $error("bus field not divide-by-two after boot");

  AST_BUS_COINCIDE: assert property (
    bus_flash_clk_en |-> core_clk_en)
    else $error("bus enable without a core enable");

  AST_NO_MIDSWITCH: assert property (
    !core_clk_en |=> $stable(core_active) && $stable(bus_active))
    else $error("ratio changed inside a clock period");

  AST_CORE_LANE_KEEP: assert property (
    (wr_ctrl && !pstrb[scdiv_pkg::CORE_LANE]) |=> $stable(ctrl_reg.core))
    else $error("core field changed with its lane off");

  AST_BUS_LANE_KEEP: assert property (
    (wr_ctrl && !pstrb[scdiv_pkg::BUS_LANE]) |=> $stable(ctrl_reg.bus))
    else $error("bus field changed with its lane off");

  AST_CTRL_HOLD: assert property (
    (!wr_ctrl && boot_reg != scdiv_pkg::BOOT_LOAD) |=> $stable(ctrl_reg))
    else $error("divider register changed without a write");

  AST_LOCK_SILENT: assert property (
    (access && pwrite && ctrl_hit) |-> !pslverr)
    else $error("control write answered with an error");

  AST_BOOT_BUS: assert property (
    (boot_reg == scdiv_pkg::BOOT_LOAD) |=> ctrl_reg.bus == scdiv_pkg::BUS_RESET)
    else $error("bus field not reloaded at boot load");

endmodule
`default_nettype wire

// file: sim/tb_system_clock_divider.sv
/*
  Self-checking bench for the system clock divider: boot load, register
  access over APB, ratio periods, the low power write lock.
  Assumes the design answers APB itself and holds its own assertions.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_system_clock_divider;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, low_run;
  logic core_clk_en, bus_flash_clk_en;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  logic [1:0] boot;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;

  scdiv_top scdiv_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .very_low_power_run_mode(low_run), .boot_divide_option_bits(boot),
    .core_clk_en(core_clk_en), .bus_flash_clk_en(bus_flash_clk_en)
  );

  // ----------------------------------------------------------------
  // clock, initial values and hang guard
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = '0;
    low_run = 1'b0;
    boot = 2'b00;
  end

  // longest scenario is about a thousand cycles; this is far above the run
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // reset held five cycles; boot pins settle before release
  task automatic do_reset(input logic [1:0] b);
    @(posedge pclk);
    presetn <= 1'b0;
    boot <= b;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // one APB transfer; waits for pready however long the slave stalls,
  // only the bench timeout ends a wait
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // cycles between two pulses of the chosen enable, sampled mid-cycle
  task automatic gap(input bit bus, output int p);
    int n;
    n = 0;
    p = 1;
    do begin
      @(negedge pclk);
      n++;
    end while ((bus ? bus_flash_clk_en : core_clk_en) !== 1'b1 && n < 300);
    @(negedge pclk);
    while ((bus ? bus_flash_clk_en : core_clk_en) !== 1'b1 && p < 300) begin
      @(negedge pclk);
      p++;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  // every boot option loads its core code, bus code stays divide-by-two
  task automatic t_boot();
    logic [3:0] codes [4];
    logic [31:0] rd;
    logic err;
    codes = '{scdiv_pkg::BOOT_CODE_0, scdiv_pkg::BOOT_CODE_1,
              scdiv_pkg::BOOT_CODE_2, scdiv_pkg::BOOT_CODE_3};
    for (int i = 0; i < 4; i++) begin
      do_reset(i[1:0]);
      apb(1'b0, 16'h1044, 32'h0000_0000, 4'h0, rd, err);
      chk("boot ctrl", rd, {codes[i], 9'h000, 3'h1, 16'h0000});
      chk("boot err", {31'h0, err}, 32'h0000_0000);
    end
    $display("done boot load");
  endtask

  // reserved bits ignore writes and read zero; lanes gate fields
  task automatic t_fields();
    logic [31:0] rd;
    logic err;
    apb(1'b1, 16'h1044, 32'hFFFF_FFFF, 4'hF, rd, err);
    apb(1'b0, 16'h1044, 32'h0000_0000, 4'h0, rd, err);
    chk("ctrl ones", rd, 32'hF007_0000);
    apb(1'b1, 16'h1044, 32'h0000_0000, 4'h4, rd, err);
    apb(1'b0, 16'h1044, 32'h0000_0000, 4'h0, rd, err);
    chk("lane2 only", rd, 32'hF000_0000);
    apb(1'b0, 16'h1048, 32'h0000_0000, 4'h0, rd, err);
    chk("unmapped data", rd, 32'h0000_0000);
    chk("unmapped err", {31'h0, err}, 32'h0000_0001);
    $display("done fields");
  endtask

  // periods follow code plus one; switching never shortens a period
  task automatic t_ratio();
    logic [3:0] cc [4];
    logic [2:0] bc [4];
    logic [31:0] rd;
    logic err;
    int p, oc;
    cc = '{4'h0, 4'hF, 4'h2, 4'h1};
    bc = '{3'h0, 3'h7, 3'h3, 3'h1};
    oc = 15;
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 16'h1044, {cc[k], 9'h1FF, bc[k], 16'hFFFF}, 4'hF, rd, err);
      gap(1'b0, p);
      chk("switch gap", {31'h0, p == oc + 1 || p == cc[k] + 1}, 32'h0000_0001);
      gap(1'b0, p);
      chk("core period", p, cc[k] + 1);
      gap(1'b1, p);
      gap(1'b1, p);
      gap(1'b1, p);
      chk("bus period", p, (cc[k] + 1) * (bc[k] + 1));
      oc = cc[k];
    end
    $display("done ratios");
  endtask

  // writes dropped while the low power run pin is high
  task automatic t_lock();
    logic [31:0] rd;
    logic err;
    apb(1'b1, 16'h1044, 32'h3002_0000, 4'hF, rd, err);
    @(posedge pclk);
    low_run <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, 16'h1044, 32'hA005_0000, 4'hF, rd, err);
    chk("lock err", {31'h0, err}, 32'h0000_0000);
    apb(1'b0, 16'h1044, 32'h0000_0000, 4'h0, rd, err);
    chk("locked ctrl", rd, 32'h3002_0000);
    @(posedge pclk);
    low_run <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b1, 16'h1044, 32'hA005_0000, 4'hF, rd, err);
    apb(1'b0, 16'h1044, 32'h0000_0000, 4'h0, rd, err);
    chk("unlocked ctrl", rd, 32'hA005_0000);
    $display("done lock");
  endtask

  initial begin
    t_boot();
    t_fields();
    t_ratio();
    t_lock();
    conclude();
  end
endmodule
`default_nettype wire
